// *** shared/itr_consts.svh ***
// constants for the terminal addressing and response block
// assumes a 100 MHz system clock; included by the package, its macros used by logic
`ifndef ITR_CONSTS_SVH
`define ITR_CONSTS_SVH
// ----------------------------------------
// addressing
// ----------------------------------------
`define ITR_EQUIP_W 4
`define ITR_STATION_W 7
`define ITR_CHANNEL_W 12
`define ITR_DATA_W 16
`define ITR_IRQ_W 15
`define ITR_EQUIP_DEFAULT 4'h8
`define ITR_STN_OWN_STATUS 7'h00
`define ITR_STN_SYS_STATUS 7'h01
// ----------------------------------------
// timing
// ----------------------------------------
`define ITR_CLK_PERIOD_NS 10
`define ITR_ACK_WINDOW_NS 2000
`define ITR_ACK_WINDOW_CYC (`ITR_ACK_WINDOW_NS / `ITR_CLK_PERIOD_NS)
`define ITR_HOST_TIMEOUT_NS 4000
`define ITR_FUNC_RESET 16'h0000
`endif

// *** shared/itr_pkg.sv ***
// types for the terminal addressing and response block
// assumes itr_consts.svh is on the include path
`include "itr_consts.svh"
package itr_pkg;
    // ----------------------------------------
    // response states, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        ITR_IDLE = 5'b00001,
        ITR_WAIT = 5'b00010,
        ITR_RESP = 5'b00100,
        ITR_HOLD = 5'b01000,
        ITR_DONE = 5'b10000
    } itr_state_e;
    typedef enum logic [1:0] {
        ITR_ANS_NONE = 2'h0,
        ITR_ANS_REPLY = 2'h1,
        ITR_ANS_REJECT = 2'h2
    } itr_ans_e;
    // host command: connect, continue, read or write
    typedef struct packed {
        logic connect;
        logic cont;
        logic read;
        logic write;
        logic [`ITR_EQUIP_W-1:0] equip;
        logic [`ITR_STATION_W-1:0] station;
        logic [`ITR_CHANNEL_W-1:0] channel;
    } itr_cmd_s;
    // device side bus status from the addressed device
    typedef struct packed {
        logic here;
        logic ready;
        logic reject_flag;
    } itr_dev_s;
endpackage

// *** logic/itr_ack_timer.sv ***
// window timer for the device acknowledge after an execute
// assumes start is a one-cycle pulse, synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module itr_ack_timer
    import itr_pkg::*;
#(
    parameter int CYCLES = `ITR_ACK_WINDOW_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic expired_o
);
    logic [15:0] count;
    // ----------------------------------------
    // countdown
    // ----------------------------------------
    // expired stays high until the next start
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || start_i) begin
            count <= 16'(CYCLES);
            expired_o <= 1'b0;
        end else if (count != 16'h0000) begin
            count <= count - 16'h0001;
            expired_o <= (count == 16'h0001);
        end
    end
endmodule
`default_nettype wire

// *** logic/itr_terminal.sv ***
// terminal addressing and response control
// assumes host and device-side bus inputs are synchronous to clk_sys_i
// Operation
// (R1) absent or slow device: no response
// (R2) host rejects internally after four microseconds
// (R3) device here, not ready: reject
// (R4) reply only after successful completion
// (R5) drive fifteen interrupt lines and channel lines
// (R6) respond to assigned equipment number
// (R7) terminal owns stations zero and one
// (R8) connect selects equipment and station
// (R9) continue selects channels in connected equipment
// (R10) four-bit equipment code, sixteen codes
// (R11) seven-bit station address, 128 stations
// (R12) decode shared by all bus devices
// (R13) station zero status/function, one system status
// (R14) device acknowledges execute by dropping ready
// (R15) ready not dropped in two microseconds: none
// (R16) ready drop with reject flag: reject
// (R17) host drops request, logic returns idle
`timescale 1ns/1ps
`default_nettype none
module itr_terminal
    import itr_pkg::*;
#(
    parameter logic [`ITR_EQUIP_W-1:0] EQUIP_NUM = `ITR_EQUIP_DEFAULT,
    parameter int ACK_CYCLES = `ITR_ACK_WINDOW_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire itr_cmd_s cmd_i,
    input wire logic [`ITR_DATA_W-1:0] wdata_i,
    input wire itr_dev_s dev_i,
    input wire logic [`ITR_DATA_W-1:0] dev_rdata_i,
    input wire logic [`ITR_DATA_W-1:0] sys_status_i,
    input wire logic timer_gen_here_i,
    input wire logic timer_gen_irq_i,
    input wire logic [`ITR_IRQ_W-1:0] dev_irq_i,
    output logic reply_o,
    output logic reject_o,
    output logic [`ITR_DATA_W-1:0] rdata_o,
    output logic read_exec_o,
    output logic write_exec_o,
    output logic [`ITR_STATION_W-1:0] bus_station_o,
    output logic [`ITR_CHANNEL_W-1:0] bus_channel_o,
    output logic bus_chan_mode_o,
    output logic [`ITR_DATA_W-1:0] bus_wdata_o,
    output logic [`ITR_DATA_W-1:0] function_o,
    output logic timer_gen_ack_o,
    output logic [`ITR_IRQ_W-1:0] irq_o,
    output logic connected_o
);
    itr_state_e state;
    itr_ans_e answer;
    logic [`ITR_STATION_W-1:0] station;
    logic chan_mode;
    logic exec_start;
    logic ack_expired;
    logic request;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // the equipment field is four bits, so 16 codes
    function automatic logic equip_match(input logic [`ITR_EQUIP_W-1:0] eq);
        return eq == EQUIP_NUM; // R6 R10
    endfunction

    assign request = cmd_i.read || cmd_i.write;
    // leading edge of a transfer starts the ack window
    assign exec_start = (state == ITR_IDLE) && request && connected_o
        && !cmd_i.connect && !cmd_i.cont;

    itr_ack_timer #(
        .CYCLES(ACK_CYCLES)
    ) u_ack_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(exec_start),
        .expired_o(ack_expired)
    );

    // ----------------------------------------
    // connection and selection
    // ----------------------------------------
    // a connect to another equipment drops this one off the channel
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            connected_o <= 1'b0;
            station <= '0;
            chan_mode <= 1'b0;
            bus_channel_o <= '0;
        end else if (state == ITR_IDLE && cmd_i.connect) begin
            connected_o <= equip_match(cmd_i.equip); // R8
            station <= cmd_i.station; // R11
            chan_mode <= 1'b0;
        end else if (state == ITR_IDLE && cmd_i.cont && connected_o) begin
            chan_mode <= 1'b1; // R9
            bus_channel_o <= cmd_i.channel; // R9
        end
    end

    // ----------------------------------------
    // response state machine
    // ----------------------------------------
    // one engine serves every device on the bus in turn
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state <= ITR_IDLE;
            answer <= ITR_ANS_NONE;
        end else begin
            case (state)
                ITR_IDLE: begin
                    answer <= ITR_ANS_NONE;
                    if (exec_start) begin // R12
                        if (!chan_mode && station == `ITR_STN_OWN_STATUS) begin
                            answer <= ITR_ANS_REPLY; // R7 R13
                            state <= ITR_RESP;
                        end else if (!chan_mode && station == `ITR_STN_SYS_STATUS) begin
                            if (cmd_i.read)
                                answer <= ITR_ANS_REPLY; // R13
                            else if (!timer_gen_here_i)
                                answer <= ITR_ANS_NONE;
                            else if (timer_gen_irq_i)
                                answer <= ITR_ANS_REPLY;
                            else
                                answer <= ITR_ANS_REJECT;
                            state <= ITR_RESP;
                        end else if (!dev_i.here) begin
                            answer <= ITR_ANS_NONE; // R1
                            state <= ITR_RESP;
                        end else if (!dev_i.ready) begin
                            answer <= ITR_ANS_REJECT; // R3
                            state <= ITR_RESP;
                        end else begin
                            state <= ITR_WAIT;
                        end
                    end
                end
                ITR_WAIT: begin
                    // device drops ready to acknowledge
                    if (!dev_i.ready) begin // R14
                        answer <= dev_i.reject_flag ? ITR_ANS_REJECT : ITR_ANS_REPLY; // R16 R4
                        state <= ITR_RESP;
                    end else if (ack_expired) begin
                        answer <= ITR_ANS_NONE; // R15 R1
                        state <= ITR_RESP;
                    end else if (!request) begin
                        state <= ITR_DONE;
                    end
                end
                ITR_RESP: begin
                    state <= ITR_HOLD;
                end
                ITR_HOLD: begin
                    // host drops its request after answer or its own timeout
                    if (!request)
                        state <= ITR_DONE; // R17 R2
                end
                ITR_DONE: begin
                    answer <= ITR_ANS_NONE;
                    state <= ITR_IDLE; // R17
                end
                default: state <= ITR_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // host answer lines
    // ----------------------------------------
    // answers stand from RESP until the host releases the request
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reply_o <= 1'b0;
            reject_o <= 1'b0;
        end else begin
            reply_o <= (state == ITR_RESP || state == ITR_HOLD) && request
                && answer == ITR_ANS_REPLY; // R4
            reject_o <= (state == ITR_RESP || state == ITR_HOLD) && request
                && answer == ITR_ANS_REJECT; // R3 R16
        end
    end

    // ----------------------------------------
    // execute strobes and bus addressing
    // ----------------------------------------
    // execute held while waiting so the device sees a level
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            read_exec_o <= 1'b0;
            write_exec_o <= 1'b0;
            bus_station_o <= '0;
            bus_chan_mode_o <= 1'b0;
            bus_wdata_o <= '0;
        end else begin
            read_exec_o <= (next_exec() && cmd_i.read);
            write_exec_o <= (next_exec() && cmd_i.write);
            bus_station_o <= station;
            bus_chan_mode_o <= chan_mode;
            if (exec_start)
                bus_wdata_o <= wdata_i;
        end
    end

    // true while an external device transfer is in flight
    function automatic logic next_exec();
        return (state == ITR_WAIT) && dev_i.ready && !ack_expired;
    endfunction

    // ----------------------------------------
    // own stations: function, status, read data
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            function_o <= `ITR_FUNC_RESET;
            timer_gen_ack_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            timer_gen_ack_o <= 1'b0;
            if (exec_start && !chan_mode && station == `ITR_STN_OWN_STATUS) begin
                if (cmd_i.write)
                    function_o <= wdata_i; // R13
                else
                    rdata_o <= {connected_o, chan_mode, 2'h0, EQUIP_NUM, function_o[7:0]};
            end else if (exec_start && !chan_mode && station == `ITR_STN_SYS_STATUS) begin
                if (cmd_i.read)
                    rdata_o <= sys_status_i; // R13
                else
                    timer_gen_ack_o <= timer_gen_here_i && timer_gen_irq_i;
            end else if (state == ITR_WAIT && !dev_i.ready) begin
                rdata_o <= dev_rdata_i;
            end
        end
    end

    // ----------------------------------------
    // interrupt line transmitters
    // ----------------------------------------
    // registered pass-through; no masking here by design
    always_ff @(posedge clk_sys_i) begin
        if (reset_i)
            irq_o <= '0;
        else
            irq_o <= dev_irq_i; // R5
    end
endmodule
`default_nettype wire

// *** dv/itr_terminal_properties.sv ***
// port checker for the terminal response and addressing block
// assumes one clock domain; reset_i is synchronous, active high
`timescale 1ns/1ps
`default_nettype none
module itr_terminal_chk
    import itr_pkg::*;
#(
    parameter logic [3:0] EQUIP_NUM = 4'h8,
    parameter int ACK_CYCLES = 8
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire itr_cmd_s cmd_i,
    input wire itr_dev_s dev_i,
    input wire logic timer_gen_here_i,
    input wire logic [14:0] dev_irq_i,
    input wire logic reply_o,
    input wire logic reject_o,
    input wire logic read_exec_o,
    input wire logic write_exec_o,
    input wire logic timer_gen_ack_o,
    input wire logic [14:0] irq_o,
    input wire logic connected_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    logic req;
    logic exec;
    int unsigned req_len;
    assign req = cmd_i.read || cmd_i.write;
    assign exec = read_exec_o || write_exec_o;
    // cycles a request has waited unanswered; zero once released
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !req) begin
            req_len <= 0;
        end else if (!reply_o && !reject_o) begin
            req_len <= req_len + 1;
        end
    end
    resp_hold_a: assert property (reply_o && req |=> reply_o)
        else $error("reply dropped while request held");
    resp_clear_a: assert property ((reply_o || reject_o) && !req |=> !reply_o && !reject_o)
        else $error("answer kept after release");
    one_answer_a: assert property (!(reply_o && reject_o))
        else $error("reply and reject together");
    exec_drop_a: assert property (exec && !dev_i.ready |=> !exec)
        else $error("execute kept after ready dropped");
    reply_done_a: assert property (exec && !dev_i.ready && !dev_i.reject_flag |-> ##[1:2] reply_o)
        else $error("no reply after clean acknowledge");
    reject_flag_a: assert property (exec && !dev_i.ready && dev_i.reject_flag |-> ##[1:2] reject_o)
        else $error("no reject with reject flag");
    answer_conn_a: assert property ($rose(reply_o || reject_o) |-> $past(connected_o))
        else $error("answer while not connected");
    exec_conn_a: assert property ($rose(exec) |-> connected_o && $past(req))
        else $error("execute without connected request");
    answer_late_a: assert property ($rose(reply_o || reject_o) |-> req_len <= ACK_CYCLES + 4)
        else $error("answer after acknowledge window");
    irq_copy_a: assert property (1'b1 |=> irq_o == $past(dev_irq_i))
        else $error("interrupt lines not copied");
    ack_pulse_a: assert property (timer_gen_ack_o |-> timer_gen_here_i ##1 !timer_gen_ack_o)
        else $error("timer acknowledge not a single pulse");
    connect_a: assert property (cmd_i.connect && !req && !reply_o && !reject_o
        && cmd_i.equip == EQUIP_NUM |=> connected_o)
        else $error("own equipment connect ignored");
endmodule
bind itr_terminal itr_terminal_chk #(.EQUIP_NUM(EQUIP_NUM), .ACK_CYCLES(ACK_CYCLES))
    i_itr_terminal_chk (.clk_sys_i, .reset_i, .cmd_i, .dev_i, .timer_gen_here_i, .dev_irq_i,
    .reply_o, .reject_o, .read_exec_o, .write_exec_o, .timer_gen_ack_o, .irq_o, .connected_o);
`default_nettype wire

// *** dv/itr_dev_model.sv ***
// bus device model: drops ready lag_i cycles into an execute
// assumes the bench sets presence, readiness and lag; lag 0 never answers
`timescale 1ns/1ps
`default_nettype none
module itr_dev_model
    import itr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic exec_i,
    input wire itr_dev_s mode_i,
    input wire logic [7:0] lag_i,
    input wire logic [15:0] data_i,
    output itr_dev_s dev_o,
    output logic [15:0] rdata_o
);
    logic [7:0] cnt;
    logic acked;
    // execute length, saturating so a stuck execute cannot wrap
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !exec_i) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    // data only valid while acknowledging; otherwise the inverse
    assign acked = exec_i && lag_i != 8'h00 && cnt >= lag_i;
    assign dev_o.here = mode_i.here;
    assign dev_o.ready = mode_i.ready && !acked;
    assign dev_o.reject_flag = mode_i.reject_flag;
    assign rdata_o = acked ? data_i : ~data_i;
endmodule
`default_nettype wire

// *** dv/test_io_terminal_response_addressing.sv ***
// self-checking bench for the terminal response and addressing block
// assumes itr_pkg compiled first; the checker binds itself to the design
`timescale 1ns/1ps
`default_nettype none
module test_io_terminal_response_addressing
    import itr_pkg::*;
;
    localparam int ACK = 8;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    itr_cmd_s cmd = '0;
    itr_dev_s mode = '0;
    itr_dev_s dev;
    logic [15:0] wdata = 16'h0000, sys_st = 16'h0000, ddata = 16'h0000;
    logic [15:0] dev_rd, rdata, bwd, func;
    logic tg_here = 1'b0, tg_irq = 1'b0, seen = 1'b0;
    logic [14:0] dev_irq = 15'h0000;
    logic reply, reject, rexec, wexec, chan_mode, conn, tg_ack;
    logic [6:0] bstn;
    logic [11:0] bchan;
    logic [7:0] lag = 8'h01;
    int n_mismatch = 0, checks = 0;
    int n_ack = 0;
    logic [31:0] seed = 32'd53;
    logic [18:0] notes[$];
    // mode, answer, lag kind (0 prompt, 1 never, 2 late)
    logic [6:0] tab [6] = '{7'h64, 7'h78, 7'h48, 7'h00, 7'h61, 7'h62};
    always #5 clk_sys_i = ~clk_sys_i;
    itr_terminal #(.EQUIP_NUM(4'h8), .ACK_CYCLES(ACK)) i_itr_terminal (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .cmd_i(cmd), .wdata_i(wdata), .dev_i(dev), .dev_rdata_i(dev_rd),
        .sys_status_i(sys_st), .timer_gen_here_i(tg_here), .timer_gen_irq_i(tg_irq),
        .dev_irq_i(dev_irq), .reply_o(reply), .reject_o(reject), .rdata_o(rdata),
        .read_exec_o(rexec), .write_exec_o(wexec), .bus_station_o(bstn),
        .bus_channel_o(bchan), .bus_chan_mode_o(chan_mode), .bus_wdata_o(bwd),
        .function_o(func), .timer_gen_ack_o(tg_ack), .irq_o(), .connected_o(conn));
    itr_dev_model i_itr_dev_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .exec_i(rexec || wexec), .mode_i(mode), .lag_i(lag), .data_i(ddata),
        .dev_o(dev), .rdata_o(dev_rd));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic bad(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) bad("value differs");
    endtask
    task automatic cmp_ans(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) bad("wrong answer");
    endtask
    // connect (con=1) or continue (con=0), held for one edge
    task automatic command(input logic con, input logic [6:0] st, input logic [11:0] ch);
        @(posedge clk_sys_i);
        cmd.connect <= con;
        cmd.cont <= !con;
        cmd.equip <= 4'h8;
        cmd.station <= st;
        cmd.channel <= ch;
        @(posedge clk_sys_i);
        cmd.connect <= 1'b0;
        cmd.cont <= 1'b0;
        // bus copies lag the selection by one edge, so wait for them to settle
        repeat (2) @(posedge clk_sys_i);
    endtask
    // one transfer; the host gives up after 40 cycles without an answer
    task automatic xfer(input logic rd, input logic [1:0] ea, input logic [15:0] ed,
        input logic [15:0] wd);
        int i;
        logic [18:0] n;
        notes.push_back({rd, ea, ed});
        @(posedge clk_sys_i);
        cmd.read <= rd;
        cmd.write <= !rd;
        wdata <= wd;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_sys_i);
            if (reply || reject) break;
        end
        if (i == 40) begin
            n = notes.pop_front();
            cmp_ans(2'b00, n[17:16]);
            if (n[17:16] != 2'b00) finish_test();
        end
        @(posedge clk_sys_i);
        cmd.read <= 1'b0;
        cmd.write <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    // oldest note against each answer as it rises
    always @(negedge clk_sys_i) begin
        logic [18:0] n;
        if ((reply || reject) && !seen) begin
            if (notes.size() == 0) begin
                bad("unexpected answer");
            end else begin
                n = notes.pop_front();
                cmp_ans({reject, reply}, n[17:16]);
                if (n[18] && reply) cmp(rdata, n[15:0]);
            end
        end
        seen <= reply || reject;
    end
    // timing generator acknowledge pulses seen so far
    always @(negedge clk_sys_i) begin
        if (tg_ack) n_ack++;
    end
    // free-running interrupt traffic from the bus devices
    always @(posedge clk_sys_i) begin
        dev_irq <= 15'(rnd());
    end
    initial begin
        int k;
        logic [15:0] v;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        xfer(1'b1, 2'b00, 16'h0000, 16'h0000);
        @(posedge clk_sys_i);
        cmd.equip <= 4'h9;
        cmd.connect <= 1'b1;
        @(posedge clk_sys_i);
        cmd.connect <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        cmp({15'h0000, conn}, 16'h0000);
        xfer(1'b0, 2'b00, 16'h0000, 16'h1234);
        command(1'b1, 7'h00, 12'h000);
        cmp({15'h0000, conn}, 16'h0001);
        v = 16'(rnd());
        xfer(1'b0, 2'b01, 16'h0000, v);
        cmp(func, v);
        xfer(1'b1, 2'b01, {4'h8, 4'h8, v[7:0]}, 16'h0000);
        command(1'b1, 7'h01, 12'h000);
        v = 16'(rnd());
        sys_st <= v;
        xfer(1'b1, 2'b01, v, 16'h0000);
        xfer(1'b0, 2'b00, 16'h0000, 16'h0000);
        tg_here <= 1'b1;
        xfer(1'b0, 2'b10, 16'h0000, 16'h0000);
        tg_irq <= 1'b1;
        xfer(1'b0, 2'b01, 16'h0000, 16'h0000);
        cmp(16'(n_ack), 16'h0001);
        command(1'b1, 7'h05, 12'h000);
        for (k = 0; k < 12; k++) begin
            v = 16'(rnd());
            ddata <= v;
            mode <= tab[k / 2][6:4];
            lag <= tab[k / 2][1] ? 8'd12 : tab[k / 2][0] ? 8'd0 : 8'(1 + rnd() % 4);
            xfer(k[0], tab[k / 2][3:2], v, v);
            if (k == 0) cmp(bwd, v);
            cmp({9'h000, bstn}, 16'h0005);
        end
        v = 16'(rnd());
        ddata <= v;
        mode <= 3'b110;
        lag <= 8'd2;
        command(1'b0, 7'h05, v[11:0]);
        cmp({15'h0000, chan_mode}, 16'h0001);
        cmp({4'h0, bchan}, {4'h0, v[11:0]});
        xfer(1'b1, 2'b01, v, 16'h0000);
        command(1'b1, 7'h7f, 12'h000);
        cmp({9'h000, bstn}, 16'h007f);
        cmp({15'h0000, chan_mode}, 16'h0000);
        xfer(1'b0, 2'b01, v, v);
        finish_test();
    end
endmodule
`default_nettype wire
